// File: logic/kli_pkg.sv
// package: register map, reset values and carrier types for the keypad level interrupt unit
`default_nettype none

package kli_pkg;

    localparam int unsigned KLI_LINES = 8;

    localparam logic [7:0] KLI_ADDR_LEVEL_SELECT = 8'h9C;
    localparam logic [7:0] KLI_ADDR_LINE_ENABLE  = 8'h9D;
    localparam logic [7:0] KLI_ADDR_LINE_FLAGS   = 8'h9E;

    localparam logic [7:0] KLI_RST_LEVEL_SELECT  = 8'h00;
    localparam logic [7:0] KLI_RST_LINE_ENABLE   = 8'h00;
    localparam logic [7:0] KLI_RST_LINE_FLAGS    = 8'h00;
    // synchroniser reset matches the pulled-up idle pins
    localparam logic [7:0] KLI_RST_PORT_SYNC     = 8'hFF;

    // special function register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } kli_sfr_req_t;

    // power mode controls from the core
    typedef struct packed {
        logic idleSet;
        logic powerDownSet;
    } kli_pwr_req_t;

endpackage : kli_pkg

`default_nettype wire

// File: logic/kli_line_detect.sv
// module: per-line level match and sticky flag for the keypad unit
`default_nettype none

module kli_line_detect
    import kli_pkg::*;
#(
    parameter int unsigned LINES = 8
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // configuration and raw port
    input  wire logic [LINES-1:0] levelSelect,
    input  wire logic [LINES-1:0] portRaw,
    // flag control
    input  wire logic             clearAll,
    // results
    output var  logic [LINES-1:0] flags,
    output logic      [LINES-1:0] levelMatchAsync
);

    logic [LINES-1:0] syncA_r;
    logic [LINES-1:0] syncB_r;
    logic [LINES-1:0] match;
    logic [LINES-1:0] flags_r;
    logic [LINES-1:0] flags_nxt;

    // xnor: select 0 matches low, 1 matches high
    assign match           = ~(syncB_r ^ levelSelect);
    // unclocked copy for power-down wake-up
    assign levelMatchAsync = ~(portRaw ^ levelSelect);
    // set wins over a coinciding clearing read
    assign flags_nxt       = (clearAll ? '0 : flags_r) | match;
    assign flags           = flags_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // released pins read high, so no false low match after reset
            syncA_r <= KLI_RST_PORT_SYNC[LINES-1:0];
            syncB_r <= KLI_RST_PORT_SYNC[LINES-1:0];
        end
        else
        begin
            syncA_r <= portRaw;
            syncB_r <= syncA_r;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flags_r <= KLI_RST_LINE_FLAGS[LINES-1:0];
        else
            flags_r <= flags_nxt;
    end

endmodule : kli_line_detect

`default_nettype wire

// File: logic/keypad_level_interrupt.sv
// module: keypad level interrupt unit with its three special function registers
`default_nettype none

module keypad_level_interrupt
    import kli_pkg::*;
#(
    parameter int unsigned LINES = KLI_LINES
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // core register access
    input  wire kli_pkg::kli_sfr_req_t sfrReq,
    output logic      [7:0]       sfrRdata,
    output logic                  sfrRvalid,
    // core interrupt enable and power modes
    input  wire logic             keypadGlobalEnable,
    input  wire kli_pkg::kli_pwr_req_t pwrReq,
    // keypad port pins
    input  wire logic [LINES-1:0] keypadPort,
    // keypad function claims per pin
    output logic      [LINES-1:0] keypadLineClaim,
    // interrupt and power outputs
    output logic                  keypadIrq,
    output logic                  idleModeBit,
    output logic                  powerDownBit,
    output logic                  wakeAsync
);

    logic [LINES-1:0] levelSelect_r;
    logic [LINES-1:0] lineEnable_r;
    logic [LINES-1:0] flags;
    logic [LINES-1:0] matchAsync;
    logic [7:0]       sfrRdata_r;
    logic             sfrRvalid_r;
    logic             irq_r;
    logic             idle_r;
    logic             pd_r;
    logic             wake_r;

    wire  logic       selLevel   = (sfrReq.addr == KLI_ADDR_LEVEL_SELECT);
    wire  logic       selEnable  = (sfrReq.addr == KLI_ADDR_LINE_ENABLE);
    wire  logic       selFlags   = (sfrReq.addr == KLI_ADDR_LINE_FLAGS);
    wire  logic       wrLevel    = sfrReq.wr & selLevel;
    wire  logic       wrEnable   = sfrReq.wr & selEnable;
    // reading the flags clears them; writes to it are ignored
    wire  logic       rdFlags    = sfrReq.rd & selFlags;
    wire  logic       anyEnabled = |(flags & lineEnable_r);
    wire  logic       irq_nxt    = anyEnabled & keypadGlobalEnable;
    wire  logic [7:0] rdMux      = selLevel  ? 8'(levelSelect_r) :
                                   selEnable ? 8'(lineEnable_r)  :
                                   selFlags  ? 8'(flags)         : 8'h00;
    // interrupt leaves idle; an enabled flagged line with global enable also wakes power-down
    wire  logic       idle_nxt   = irq_nxt ? 1'b0 : (pwrReq.idleSet | idle_r);
    wire  logic       pd_nxt     = irq_nxt ? 1'b0 : (pwrReq.powerDownSet | pd_r);

    kli_line_detect #(
        .LINES           (LINES)
    ) u_detect (
        .clk             (clk),
        .rstn            (rstn),
        .levelSelect     (levelSelect_r),
        .portRaw         (keypadPort),
        .clearAll        (rdFlags),
        .flags           (flags),
        .levelMatchAsync (matchAsync)
    );

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            levelSelect_r <= KLI_RST_LEVEL_SELECT[LINES-1:0];
            lineEnable_r  <= KLI_RST_LINE_ENABLE[LINES-1:0];
        end
        else
        begin
            if (wrLevel)
                levelSelect_r <= sfrReq.wdata[LINES-1:0];
            if (wrEnable)
                lineEnable_r  <= sfrReq.wdata[LINES-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sfrRdata_r  <= 8'h00;
            sfrRvalid_r <= 1'b0;
            irq_r       <= 1'b0;
            idle_r      <= 1'b0;
            pd_r        <= 1'b0;
            wake_r      <= 1'b0;
        end
        else
        begin
            sfrRdata_r  <= sfrReq.rd ? rdMux : 8'h00;
            sfrRvalid_r <= sfrReq.rd;
            irq_r       <= irq_nxt;
            idle_r      <= idle_nxt;
            pd_r        <= pd_nxt;
            wake_r      <= pd_nxt & keypadGlobalEnable & |(matchAsync & lineEnable_r);
        end
    end

    // claims are wired straight from the enable flops so disabled pins stay plain port I/O
    assign keypadLineClaim = lineEnable_r;
    assign sfrRdata        = sfrRdata_r;
    assign sfrRvalid       = sfrRvalid_r;
    assign keypadIrq       = irq_r;
    assign idleModeBit     = idle_r;
    assign powerDownBit    = pd_r;
    assign wakeAsync       = wake_r;

endmodule : keypad_level_interrupt

`default_nettype wire

// File: tb/kli_keypad_model.sv
// partner: keypad switches on the port lines
`default_nettype none
module kli_keypad_model
(
    // pressed keys and port pins
    input  wire logic [7:0] pressed,
    output logic      [7:0] keypadPort
);
    timeunit 1ns;
    timeprecision 1ps;
    assign keypadPort = ~pressed; // pull-ups hold released lines high
endmodule : kli_keypad_model
`default_nettype wire

// File: tb/kli_monitor.sv
// checker: port relations of the keypad unit
`default_nettype none
module kli_monitor
    import kli_pkg::*;
#(parameter int unsigned LINES = 8)
(
    input wire logic clk, rstn, sfrRvalid, keypadGlobalEnable, keypadIrq, idleModeBit, powerDownBit, wakeAsync,
    input wire kli_pkg::kli_sfr_req_t sfrReq,
    input wire kli_pkg::kli_pwr_req_t pwrReq,
    input wire logic [7:0] sfrRdata,
    input wire logic [LINES-1:0] keypadPort, keypadLineClaim
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire mapped = sfrReq.addr inside {KLI_ADDR_LEVEL_SELECT, KLI_ADDR_LINE_ENABLE, KLI_ADDR_LINE_FLAGS};
    sequence quietS;
        !$past(sfrReq.rd) && !$past(sfrReq.wr);
    endsequence
    read_answer_a: assert property (sfrReq.rd |=> sfrRvalid) else $error("no answer");
    valid_cause_a: assert property (sfrRvalid |-> $past(sfrReq.rd)) else $error("stray valid");
    unmapped_zero_a: assert property (sfrReq.rd && !mapped |=> sfrRdata == 8'h00) else $error("bad data");
    global_gate_a: assert property (!keypadGlobalEnable |=> !keypadIrq) else $error("irq gated");
    irq_sticky_a: assert property (keypadIrq && keypadGlobalEnable ##0 quietS |=> keypadIrq)
        else $error("irq dropped");
    wake_clears_a: assert property ($rose(keypadIrq) |-> !idleModeBit && !powerDownBit) else $error("mode kept");
    idle_entry_a: assert property (pwrReq.idleSet |=> idleModeBit || keypadIrq) else $error("no idle");
    wake_in_pd_a: assert property (wakeAsync |-> powerDownBit) else $error("stray wake");
    claim_follow_a: assert property (sfrReq.wr && sfrReq.addr == KLI_ADDR_LINE_ENABLE |=>
        keypadLineClaim == $past(sfrReq.wdata[LINES-1:0])) else $error("claim lag");
endmodule : kli_monitor
bind keypad_level_interrupt kli_monitor #(.LINES(LINES)) i_mon (
    .clk                (clk),
    .rstn               (rstn),
    .sfrRvalid          (sfrRvalid),
    .keypadGlobalEnable (keypadGlobalEnable),
    .keypadIrq          (keypadIrq),
    .idleModeBit        (idleModeBit),
    .powerDownBit       (powerDownBit),
    .wakeAsync          (wakeAsync),
    .sfrReq             (sfrReq),
    .pwrReq             (pwrReq),
    .sfrRdata           (sfrRdata),
    .keypadPort         (keypadPort),
    .keypadLineClaim    (keypadLineClaim)
);
`default_nettype wire

// File: tb/test_keypad_level_interrupt.sv
// bench: random and corner scenarios for the keypad unit
`default_nettype none
module test_keypad_level_interrupt;
    timeunit 1ns;
    timeprecision 1ps;
    import kli_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ge = 1'b0, rv, irq, idle, pd, wake;
    kli_sfr_req_t req = '0;
    kli_pwr_req_t pwr = '0;
    logic [7:0] press = 8'h00, rdata, claim, port;
    int errors = 0, compares = 0;
    always #12.5 clk = ~clk;
    kli_keypad_model i_keys (.pressed(press), .keypadPort(port));
    keypad_level_interrupt i_dut (.clk(clk), .rstn(rstn), .sfrReq(req), .sfrRdata(rdata), .sfrRvalid(rv),
        .keypadGlobalEnable(ge), .pwrReq(pwr), .keypadPort(port), .keypadLineClaim(claim), .keypadIrq(irq),
        .idleModeBit(idle), .powerDownBit(pd), .wakeAsync(wake));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input bit w, input bit ck);
        cyc(1);
        req = '{a, d, w, !w};
        cyc(1);
        req = '0;
        if (ck)
        begin
            chk(rv, 1'b1);
            chk(rdata, d);
        end
    endtask : acc
    function automatic logic [7:0] hit(input logic [7:0] p, input logic [7:0] ls);
        return ~(p ^ ls);
    endfunction : hit
    task automatic test_done();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial
    begin
        logic [7:0] ls, en;
        logic w;
        void'($urandom(31231));
        cyc(4);
        rstn = 1'b1;
        for (int a = 8'h9C; a < 8'hA0; a++) acc(8'(a), 8'h00, 0, 1);
        acc(KLI_ADDR_LINE_FLAGS, 8'hFF, 1, 0);
        acc(KLI_ADDR_LINE_FLAGS, 8'h00, 0, 1);
        repeat (8)
        begin
            ls = 8'($urandom);
            en = 8'($urandom);
            press = 8'($urandom);
            ge = 1'($urandom);
            acc(KLI_ADDR_LEVEL_SELECT, ls, 1, 0);
            acc(KLI_ADDR_LINE_ENABLE, en, 1, 0);
            acc(KLI_ADDR_LEVEL_SELECT, ls, 0, 1);
            acc(KLI_ADDR_LINE_ENABLE, en, 0, 1);
            acc(KLI_ADDR_LINE_FLAGS, 8'h00, 0, 0);
            cyc(4);
            chk(claim, en);
            chk(irq, ge & |(hit(~press, ls) & en));
            acc(KLI_ADDR_LINE_FLAGS, hit(~press, ls), 0, 1);
            // back-to-back reads: a still matching line must survive the clear
            cyc(1);
            req = '{KLI_ADDR_LINE_FLAGS, 8'h00, 1'b0, 1'b1};
            cyc(1);
            chk(rdata, hit(~press, ls));
            cyc(1);
            req = '0;
            chk(rdata, hit(~press, ls));
        end
        press = 8'h00;
        ge = 1'b1;
        acc(KLI_ADDR_LEVEL_SELECT, 8'h00, 1, 0);
        acc(KLI_ADDR_LINE_ENABLE, 8'h80, 1, 0);
        acc(KLI_ADDR_LINE_FLAGS, 8'h00, 0, 0);
        for (int m = 0; m < 2; m++)
        begin
            pwr = m ? 2'b01 : 2'b10;
            cyc(1);
            pwr = '0;
            cyc(2);
            chk({idle, pd}, m ? 2'b01 : 2'b10);
            press = 8'h80;
            w = 1'b0;
            repeat (6)
            begin
                cyc(1);
                w |= wake;
            end
            chk({idle, pd, irq, w}, {3'b001, m[0]});
            press = 8'h00;
            cyc(3);
            acc(KLI_ADDR_LINE_FLAGS, 8'h80, 0, 1);
        end
        cyc(4);
        chk(irq, 1'b0);
        // mid-run reset with idle set and lines enabled
        acc(KLI_ADDR_LINE_ENABLE, 8'h5A, 1, 0);
        pwr = 2'b10;
        cyc(1);
        pwr = '0;
        rstn = 1'b0;
        cyc(2);
        chk(8'({idle, pd, irq, rv}), 8'h00);
        chk(claim, 8'h00);
        rstn = 1'b1;
        for (int a = 8'h9C; a < 8'h9F; a++) acc(8'(a), 8'h00, 0, 1);
        test_done();
    end
endmodule : test_keypad_level_interrupt
`default_nettype wire
